// *** hdl/center_terminal_map.vh ***
/*
 * Register offsets, field positions, reset values and timing counts for the
 * center-terminal configuration block.
 * Assumes a 20 MHz core clock and an 8-bit register port.
 */
`ifndef CENTER_TERMINAL_MAP_VH
`define CENTER_TERMINAL_MAP_VH

// Register offsets (index on the 8-bit address port)
`define ADDR_CONV_CFG 8'h17
`define ADDR_CT_CTRL_A 8'h18
`define ADDR_CT_CTRL_BC 8'h19
`define ADDR_CHAN_SEL_BASE 8'h05
`define ADDR_CHAN_SEL_LAST 8'h0c

// Conversion configuration fields
`define CONV_SINGLE_SHOT_BIT 3
`define CONV_LINK_BIT 2
`define CONV_COMP_BIT 1
`define CONV_WRITABLE_MASK 8'h0e
`define CONV_CFG_RESET 8'h00

// Center-terminal control A fields
`define CTA_FOOT_CH6_BIT 7
`define CTA_LEFT_CH5_BIT 6
`define CTA_RIGHT_CH7_BIT 5
`define CTA_RIGHT_CH4_BIT 4
`define CTA_POWER_BIT 3
`define CTA_SEL_HI 2
`define CTA_SEL_LO 0
`define CT_CTRL_A_RESET 8'h00

// Center-terminal control B/C fields
`define CTBC_C_POWER_BIT 7
`define CTBC_B_POWER_BIT 6
`define CTBC_B_SEL_HI 5
`define CTBC_B_SEL_LO 3
`define CTBC_C_SEL_HI 2
`define CTBC_C_SEL_LO 0
`define CT_CTRL_BC_RESET 8'h14

// Per-channel settings: input selector field and codes
`define CHAN_SEL_HI 2
`define CHAN_SEL_LO 0
`define CHAN_SETTINGS_RESET 8'h00
`define SEL_NORMAL 3'h0
`define SEL_BIAS_POS 3'h6
`define SEL_BIAS_NEG 3'h7

// Chopping clock
`define CORE_CLK_HZ 20000000
`define CHOP_HZ 8000
`define CHOP_HALF_CYCLES (`CORE_CLK_HZ / (2 * `CHOP_HZ))

`endif

// *** hdl/center_terminal_config_regs.v ***
/*
 * Configuration registers for the conversion mode, lead-off comparator power,
 * center-terminal amplifiers, augmented-lead routing and the per-channel
 * input selectors, plus the center-amplifier chopping clock.
 * Assumes a register master on core_clk with one-cycle strobes that never
 * assert together; read data appear in the cycle after the read strobe.
 */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "center_terminal_map.vh"

module center_terminal_config_regs (
	input wire core_clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output reg single_shot_mode,
	output reg center_to_bias_link,
	output reg electrode_comparator_power,
	output reg aug_foot_to_ch6,
	output reg aug_left_to_ch5,
	output reg aug_right_to_ch7,
	output reg aug_right_to_ch4,
	output reg center_amp_a_power,
	output reg center_amp_b_power,
	output reg center_amp_c_power,
	output reg [2:0] center_amp_a_select,
	output reg [2:0] center_amp_b_select,
	output reg [2:0] center_amp_c_select,
	output reg [7:0] bias_return_to_pos,
	output reg [7:0] bias_return_to_neg,
	output reg [7:0] normal_input_select,
	output reg center_chop_clk
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Full-width count kept apart so the narrowing below is explicit
	localparam integer CHOP_LAST_FULL = `CHOP_HALF_CYCLES - 1;
	localparam [12:0] CHOP_LAST = CHOP_LAST_FULL[12:0];

	function is_chan_addr;
		input [7:0] addr;
		begin
			is_chan_addr = (addr >= `ADDR_CHAN_SEL_BASE) && (addr <= `ADDR_CHAN_SEL_LAST);
		end
	endfunction

	function [2:0] chan_index;
		input [7:0] addr;
		reg [7:0] diff;
		begin
			diff = addr - `ADDR_CHAN_SEL_BASE;
			chan_index = diff[2:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Storage

	reg [7:0] conversion_and_comparator_config;
	reg [7:0] center_terminal_ctrl_a;
	reg [7:0] center_terminal_ctrl_bc;
	reg [2:0] chan_select [0:7];
	reg [12:0] chop_count;
	reg [7:0] next_rdata;
	integer i;

	// Reserved conversion bits are masked so a stray host write cannot set them
	always @(posedge core_clk) begin
		if (!rst_b) begin
			conversion_and_comparator_config <= `CONV_CFG_RESET;
			center_terminal_ctrl_a <= `CT_CTRL_A_RESET;
			center_terminal_ctrl_bc <= `CT_CTRL_BC_RESET;
			for (i = 0; i < 8; i = i + 1) begin
				chan_select[i] <= `SEL_NORMAL;
			end
		end else if (reg_write) begin
			case (reg_addr)
				`ADDR_CONV_CFG: begin
					conversion_and_comparator_config <= reg_wdata & `CONV_WRITABLE_MASK;
				end
				`ADDR_CT_CTRL_A: begin
					center_terminal_ctrl_a <= reg_wdata;
				end
				`ADDR_CT_CTRL_BC: begin
					center_terminal_ctrl_bc <= reg_wdata;
				end
				default: begin
					if (is_chan_addr(reg_addr)) begin
						chan_select[chan_index(reg_addr)] <=
							reg_wdata[`CHAN_SEL_HI:`CHAN_SEL_LO];
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port: unmapped addresses return zero

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`ADDR_CONV_CFG: next_rdata = conversion_and_comparator_config;
			`ADDR_CT_CTRL_A: next_rdata = center_terminal_ctrl_a;
			`ADDR_CT_CTRL_BC: next_rdata = center_terminal_ctrl_bc;
			default: begin
				if (is_chan_addr(reg_addr)) begin
					next_rdata = {5'h00, chan_select[chan_index(reg_addr)]};
				end
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control outputs, registered from the next stored values so each output
	// changes on the same edge as its register

	reg [7:0] next_conv;
	reg [7:0] next_cta;
	reg [7:0] next_ctbc;
	reg [2:0] next_sel [0:7];
	integer k;

	always @* begin
		next_conv = conversion_and_comparator_config;
		next_cta = center_terminal_ctrl_a;
		next_ctbc = center_terminal_ctrl_bc;
		for (k = 0; k < 8; k = k + 1) begin
			next_sel[k] = chan_select[k];
		end
		if (!rst_b) begin
			next_conv = `CONV_CFG_RESET;
			next_cta = `CT_CTRL_A_RESET;
			next_ctbc = `CT_CTRL_BC_RESET;
			for (k = 0; k < 8; k = k + 1) begin
				next_sel[k] = `SEL_NORMAL;
			end
		end else if (reg_write) begin
			case (reg_addr)
				`ADDR_CONV_CFG: next_conv = reg_wdata & `CONV_WRITABLE_MASK;
				`ADDR_CT_CTRL_A: next_cta = reg_wdata;
				`ADDR_CT_CTRL_BC: next_ctbc = reg_wdata;
				default: begin
					if (is_chan_addr(reg_addr)) begin
						next_sel[chan_index(reg_addr)] = reg_wdata[`CHAN_SEL_HI:`CHAN_SEL_LO];
					end
				end
			endcase
		end
	end

	always @(posedge core_clk) begin
		single_shot_mode <= next_conv[`CONV_SINGLE_SHOT_BIT];
		center_to_bias_link <= next_conv[`CONV_LINK_BIT];
		electrode_comparator_power <= next_conv[`CONV_COMP_BIT];
		aug_foot_to_ch6 <= next_cta[`CTA_FOOT_CH6_BIT];
		aug_left_to_ch5 <= next_cta[`CTA_LEFT_CH5_BIT];
		aug_right_to_ch7 <= next_cta[`CTA_RIGHT_CH7_BIT];
		aug_right_to_ch4 <= next_cta[`CTA_RIGHT_CH4_BIT];
		center_amp_a_power <= next_cta[`CTA_POWER_BIT];
		center_amp_a_select <= next_cta[`CTA_SEL_HI:`CTA_SEL_LO];
		center_amp_c_power <= next_ctbc[`CTBC_C_POWER_BIT];
		center_amp_b_power <= next_ctbc[`CTBC_B_POWER_BIT];
		center_amp_b_select <= next_ctbc[`CTBC_B_SEL_HI:`CTBC_B_SEL_LO];
		center_amp_c_select <= next_ctbc[`CTBC_C_SEL_HI:`CTBC_C_SEL_LO];
		for (k = 0; k < 8; k = k + 1) begin
			bias_return_to_pos[k] <= (next_sel[k] == `SEL_BIAS_POS);
			bias_return_to_neg[k] <= (next_sel[k] == `SEL_BIAS_NEG);
			normal_input_select[k] <= (next_sel[k] == `SEL_NORMAL);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Chopping clock: free-running so the artifact stays at a fixed frequency
	// whether or not any amplifier is powered

	always @(posedge core_clk) begin
		if (!rst_b) begin
			chop_count <= 13'h0000;
			center_chop_clk <= 1'b0;
		end else if (chop_count == CHOP_LAST) begin
			chop_count <= 13'h0000;
			center_chop_clk <= ~center_chop_clk;
		end else begin
			chop_count <= chop_count + 13'h0001;
		end
	end

endmodule // center_terminal_config_regs

// *** sim/center_terminal_chk.sv ***
/* Assertions on the center-terminal register block.
   Bound to the design top; sees only its ports. */
`timescale 1ns/1ps
module center_terminal_chk (
	input wire core_clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire single_shot_mode,
	input wire center_to_bias_link,
	input wire electrode_comparator_power,
	input wire aug_right_to_ch4,
	input wire [2:0] center_amp_a_select,
	input wire [2:0] center_amp_b_select,
	input wire [2:0] center_amp_c_select,
	input wire center_chop_clk
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Starts at -1 so the first half period counts like the later ones
	int n;
	logic chop_q;
	always @(posedge core_clk) begin
		chop_q <= center_chop_clk;
		n <= !rst_b ? -1 : (center_chop_clk != chop_q ? 0 : n + 1);
	end
	sequence wr(a); reg_write && reg_addr == a; endsequence
	sequence rd(a); reg_read && reg_addr == a; endsequence
	AST_CONV: assert property (wr(8'h17) |=>
		{single_shot_mode, center_to_bias_link, electrode_comparator_power}
		== $past(reg_wdata[3:1])) else $error("conv outputs wrong");
	AST_A: assert property (wr(8'h18) |=> center_amp_a_select == $past(reg_wdata[2:0])
		&& aug_right_to_ch4 == $past(reg_wdata[4])) else $error("ctrl a outputs wrong");
	AST_BC: assert property (wr(8'h19) |=> center_amp_b_select == $past(reg_wdata[5:3])
		&& center_amp_c_select == $past(reg_wdata[2:0])) else $error("ctrl bc outputs wrong");
	AST_RDBK: assert property (wr(8'h18) ##1 rd(8'h18) |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("read back wrong");
	AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside read");
	AST_DEF: assert property ($rose(rst_b) |-> !single_shot_mode &&
		center_amp_b_select == 3'h2 && center_amp_c_select == 3'h4) else $error("bad defaults");
	AST_CHOP: assert property (center_chop_clk != chop_q |-> n == 1249)
		else $error("chop half period wrong");
	AST_CHOP_MAX: assert property (n <= 1249) else $error("chop clock stuck");
endmodule // center_terminal_chk

// *** sim/host_model.sv ***
/* Host controller model driving the register port.
   Assumes the caller sits on a clock edge; the write strobe stays up until the next task, rd drops its read strobe itself. */
`timescale 1ns/1ps
module host_model (
	input wire core_clk,
	input wire [7:0] reg_rdata,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_write = 1'b0,
	output logic reg_read = 1'b0
);
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= (a == 8'h17) ? (v & 8'h0e) : v;
		reg_write <= 1'b1;
		reg_read <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule // host_model

// *** sim/center_terminal_config_regs_tb_top.sv ***
/* Self-checking bench for the center-terminal register block.
   Assumes host_model and center_terminal_chk are compiled first. */
`timescale 1ns/1ps
module center_terminal_config_regs_tb_top;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] d;
	int mismatches = 0;
	int comparisons = 0;
	wire [7:0] reg_addr, reg_wdata, reg_rdata, bias_return_to_pos, bias_return_to_neg;
	wire [7:0] normal_input_select;
	wire [2:0] center_amp_a_select, center_amp_b_select, center_amp_c_select;
	wire reg_write, reg_read, single_shot_mode, center_to_bias_link, electrode_comparator_power;
	wire aug_foot_to_ch6, aug_left_to_ch5, aug_right_to_ch7, aug_right_to_ch4, center_chop_clk;
	wire center_amp_a_power, center_amp_b_power, center_amp_c_power;
	always #25 core_clk = ~core_clk;
	center_terminal_config_regs i_center_terminal_config_regs (.*);
	host_model i_host_model (.*);
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task do_reset;
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
	endtask
	task t_defaults;
		i_host_model.rd(8'h17, d);
		check("conv", d, 8'h00);
		i_host_model.rd(8'h18, d);
		check("ctrl_a", d, 8'h00);
		i_host_model.rd(8'h19, d);
		check("ctrl_bc", d, 8'h14);
		check("normal", normal_input_select, 8'hff);
	endtask
	task t_conv;
		i_host_model.wr(8'h17, 8'h0e);
		i_host_model.rd(8'h17, d);
		check("conv", d, 8'h0e);
		check("conv_out", {5'h0, single_shot_mode, center_to_bias_link,
			electrode_comparator_power}, 8'h07);
		i_host_model.wr(8'h17, 8'h08);
		i_host_model.rd(8'h17, d);
		check("conv_out", {5'h0, single_shot_mode, center_to_bias_link,
			electrode_comparator_power}, 8'h04);
	endtask
	task t_amps;
		i_host_model.wr(8'h18, 8'ha9);
		i_host_model.rd(8'h18, d);
		check("ctrl_a", d, 8'ha9);
		i_host_model.wr(8'h19, 8'h9d);
		i_host_model.wr(8'h20, 8'hff);
		i_host_model.rd(8'h20, d);
		check("unmapped", d, 8'h00);
		check("aug", {aug_foot_to_ch6, aug_left_to_ch5, aug_right_to_ch7, aug_right_to_ch4,
			center_amp_a_power, center_amp_a_select}, 8'ha9);
		check("bc", {center_amp_c_power, center_amp_b_power, center_amp_b_select,
			center_amp_c_select}, 8'h9d);
	endtask
	task t_chan;
		i_host_model.wr(8'h05, 8'h06);
		i_host_model.wr(8'h0c, 8'h07);
		i_host_model.rd(8'h0c, d);
		check("chan8", d, 8'h07);
		check("to_pos", bias_return_to_pos, 8'h01);
		check("to_neg", bias_return_to_neg, 8'h80);
		check("normal", normal_input_select, 8'h7e);
	endtask
	initial begin
		do_reset;
		t_defaults;
		t_conv;
		t_amps;
		t_chan;
		// Long enough for two chop edges
		repeat (2600) @(posedge core_clk);
		do_reset;
		t_defaults;
		print_verdict;
	end
	initial begin
		repeat (10000) @(posedge core_clk);
		mismatches++;
		print_verdict;
	end
endmodule // center_terminal_config_regs_tb_top
bind center_terminal_config_regs center_terminal_chk i_center_terminal_chk (.*);
